// ### include/spw_defs.svh
// Purpose: offsets, field positions, reset values and companding limits
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: field ranges are used as part-selects
// Operation
// - Low-bit-first select picks serial bit order
// - Merge packs two short words per buffer word
// - First word in bits 15-0, second 31-16
// - Merged mode signals once per 32-bit word
// - Linear receive sign-extends or zero-fills by format
// - Transmit sends only the significant bits
// - B zero-fills when A compands, standard mode
// - Multichannel B uses multichannel format bit 0
// - Only A compands; even compress, odd expand
// - A-law or mu-law chosen per port
// - Expanded receive word is sign-extended linear value
// - Compressing transmit write leaves zero-filled 8-bit code
// - Compression saturates at the law maximum
// - In-place compression via transmit buffer write
// - In-place expansion via receive buffer write
// - One serial clock times both data lines
// - Serial clock is pclk over 4(divisor+1)
// - Frame sync every frame period plus one
// - Frame counter counts internal or external clock
// - Frame sync serves the configured data direction
// - Word length field holds length minus one
// - Internal clock select drives pin, else input
// - Zero frame period keeps frame sync active
`ifndef SPW_DEFS_SVH
`define SPW_DEFS_SVH
`define SPW_OFF_CTRL 8'h00
`define SPW_OFF_DIV 8'h04
`define SPW_OFF_TXA 8'h08
`define SPW_OFF_TXB 8'h0C
`define SPW_OFF_RXA 8'h10
`define SPW_OFF_RXB 8'h14
`define SPW_OFF_STAT 8'h18
`define SPW_B_ENA 0
`define SPW_B_ENB 1
`define SPW_B_XMIT 2
`define SPW_B_INTERNAL_CLOCK_SELECT 3
`define SPW_B_IFS 4
`define SPW_B_LOW_BIT_FIRST_SELECT 5
`define SPW_B_MERGE 6
`define SPW_B_MC 7
`define SPW_F_FMT 9:8
`define SPW_F_MCFMT 11:10
`define SPW_F_WLEN 16:12
`define SPW_F_CDIV 15:1
`define SPW_F_FPER 31:16
`define SPW_CTRL_RST 32'h0001_F000
`define SPW_DIV_RST 32'h0000_0000
`define SPW_ALAW_MAX 32'h0000_0FFF
`define SPW_MULAW_MAX 32'h0000_1FDE
`define SPW_MULAW_BIAS 14'h0021
`define SPW_ALAW_XOR 8'h55
`endif

// ### include/spw_pkg.sv
// Purpose: shared types of the serial port word block
// Assumes: nothing
// Notes: constants live in spw_defs.svh
package spw_pkg;
  typedef logic [31:0] spw_word_t;
  typedef enum logic {SPW_IDLE, SPW_SHIFT} spw_state_e;
endpackage

// ### rtl/spw_compand.sv
// Purpose: G.711 A-law and mu-law compressor and expander
// Assumes: two's complement linear data
// Notes: purely combinational
`timescale 1ns/10ps
`include "spw_defs.svh"

module spw_compand (
  input wire logic law_a, // 1 A-law, 0 mu-law
  input wire spw_pkg::spw_word_t lin_in, // Linear value to compress
  output logic [7:0] code_out, // Compressed code
  input wire logic [7:0] code_in, // Code to expand
  output spw_pkg::spw_word_t lin_out // Expanded linear value
);
  import spw_pkg::*;

  logic neg;
  spw_word_t mag;
  logic [13:0] m;
  logic [2:0] ex;
  logic [3:0] mt;
  logic [7:0] c;
  logic [15:0] t;

  // ----------------------------------------
  // Compression
  // ----------------------------------------
  always_comb
  begin
    neg = lin_in[31];
    mag = neg ? (32'h0 - lin_in) : lin_in;
    ex = 3'h0;
    if (law_a)
    begin
      m = (mag > `SPW_ALAW_MAX) ? 14'(`SPW_ALAW_MAX) : mag[13:0];
      for (int i = 5; i <= 11; i++)
      begin
        if (m[i])
          ex = 3'(i - 4);
      end
      mt = (ex == 3'h0) ? m[4:1] : 4'(m >> ex);
      code_out = {!neg, ex, mt} ^ `SPW_ALAW_XOR;
    end
    else
    begin
      // Saturate first so the biased value stays inside 14 bits
      m = ((mag > `SPW_MULAW_MAX) ? 14'(`SPW_MULAW_MAX) : mag[13:0]) + `SPW_MULAW_BIAS;
      for (int i = 5; i <= 12; i++)
      begin
        if (m[i])
          ex = 3'(i - 5);
      end
      mt = 4'(m >> ({1'b0, ex} + 4'h1));
      code_out = ~{neg, ex, mt};
    end
  end

  // ----------------------------------------
  // Expansion
  // ----------------------------------------
  always_comb
  begin
    c = law_a ? (code_in ^ `SPW_ALAW_XOR) : ~code_in;
    t = 16'({1'b1, c[3:0], 1'b1}) << c[6:4];
    if (law_a)
      t = (c[6:4] == 3'h0) ? {11'h0, c[3:0], 1'b1} : (t >> 1);
    else
      t = t - 16'(`SPW_MULAW_BIAS);
    // Sign-extended result, right-justified
    lin_out = (law_a ? !c[7] : c[7]) ? (32'h0 - {16'h0, t}) : {16'h0, t};
  end

endmodule // spw_compand

// ### rtl/spw_port.sv
// Purpose: serial port word format, clock divider and frame sync
// Assumes: APB slave on pclk, standard early framing
// Notes: channel A may compand; channel B is linear only
`timescale 1ns/10ps
`include "spw_defs.svh"

module spw_port #(
  parameter int PORT_INDEX = 0 // Even index compresses, odd expands
) (
  input wire logic pclk, // Peripheral clock
  input wire logic presetn, // Async reset, active low
  input wire logic [7:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire spw_pkg::spw_word_t pwdata, // APB write data
  output wire spw_pkg::spw_word_t prdata, // APB read data
  output wire logic pready, // APB ready
  output wire logic pslverr, // APB error
  input wire logic sclk_in, // Serial clock pin in
  output wire logic sclk_out, // Serial clock pin out
  output wire logic sclk_oe, // Serial clock drive enable
  input wire logic fs_in, // Frame sync pin in
  output wire logic fs_out, // Frame sync pin out
  output wire logic fs_oe, // Frame sync drive enable
  input wire logic [1:0] dat_in, // Data pins in, bit1 is B
  output wire logic [1:0] dat_out, // Data pins out
  output wire logic [1:0] dat_oe, // Data drive enables
  output wire logic [1:0] tx_evt, // Word taken from transmit buffer
  output wire logic [1:0] rx_evt // Word written to receive buffer
);
  import spw_pkg::*;

  localparam logic CAN_COMP = (PORT_INDEX % 2) == 0;

  spw_word_t ctrl_q, div_q, prdata_q;
  logic pready_q, pslverr_q;
  logic en_a, en_b, en_any, xmit, internal_clock_select, ifs, low_bit_first_select, merge, mc;
  logic [1:0] fmt, mcfmt;
  logic [4:0] wlen, idx, bcnt_q;
  logic [14:0] cdiv;
  logic [15:0] fper, hcnt_q, fcnt_q;
  logic acc, hit, wr_go, rd_go;
  logic sclk_q, sclk_oe_q, fs_q, fs_oe_q;
  logic ck_s1, ck_s2, ck_s3, fs_s1, fs_s2;
  logic [1:0] din_s1, din_s2;
  logic rise_tick, fall_tick, fs_seen, start, last;
  spw_state_e st_q;
  logic [7:0] enc_code, dec_in, rx_low_a;
  spw_word_t dec_lin, mask_w;
  wire spw_word_t tbuf_w [2];
  wire spw_word_t rbuf_w [2];
  wire [1:0] tfull_w, rfull_w;

  assign en_a = ctrl_q[`SPW_B_ENA];
  assign en_b = ctrl_q[`SPW_B_ENB];
  assign en_any = en_a || en_b;
  assign xmit = ctrl_q[`SPW_B_XMIT];
  assign internal_clock_select = ctrl_q[`SPW_B_INTERNAL_CLOCK_SELECT];
  assign ifs = ctrl_q[`SPW_B_IFS];
  assign low_bit_first_select = ctrl_q[`SPW_B_LOW_BIT_FIRST_SELECT];
  assign merge = ctrl_q[`SPW_B_MERGE];
  assign mc = ctrl_q[`SPW_B_MC];
  assign fmt = ctrl_q[`SPW_F_FMT];
  assign mcfmt = ctrl_q[`SPW_F_MCFMT];
  assign wlen = ctrl_q[`SPW_F_WLEN];
  assign cdiv = div_q[`SPW_F_CDIV];
  assign fper = div_q[`SPW_F_FPER];
  assign mask_w = ~(32'hFFFF_FFFE << wlen);

  function automatic spw_word_t put_bit(spw_word_t w, logic [4:0] i, logic b);
    w[i] = b;
    return w;
  endfunction

  // Right-justified word widened to 32 bits
  function automatic spw_word_t extend(spw_word_t w, logic [4:0] n, logic s);
    spw_word_t mk;
    mk = ~(32'hFFFF_FFFE << n);
    return (s && w[n]) ? (w | ~mk) : (w & mk);
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state: ready follows the first access cycle
  assign acc = psel && penable && !pready_q;
  assign wr_go = psel && penable && pready_q && pwrite && hit;
  assign rd_go = psel && penable && pready_q && !pwrite && hit;
  assign hit = (paddr == `SPW_OFF_CTRL) || (paddr == `SPW_OFF_DIV) ||
               (paddr == `SPW_OFF_TXA) || (paddr == `SPW_OFF_TXB) ||
               (paddr == `SPW_OFF_RXA) || (paddr == `SPW_OFF_RXB) ||
               (paddr == `SPW_OFF_STAT);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc && !hit;
      if (acc && !pwrite)
      begin
        unique case (paddr)
          `SPW_OFF_CTRL: prdata_q <= ctrl_q;
          `SPW_OFF_DIV: prdata_q <= div_q;
          `SPW_OFF_TXA: prdata_q <= tbuf_w[0];
          `SPW_OFF_TXB: prdata_q <= tbuf_w[1];
          `SPW_OFF_RXA: prdata_q <= rbuf_w[0];
          `SPW_OFF_RXB: prdata_q <= rbuf_w[1];
          `SPW_OFF_STAT: prdata_q <= {27'h0, st_q == SPW_SHIFT, rfull_w, tfull_w};
          default: prdata_q <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `SPW_CTRL_RST;
      div_q <= `SPW_DIV_RST;
    end
    else if (wr_go && paddr == `SPW_OFF_CTRL)
      ctrl_q <= pwdata;
    else if (wr_go && paddr == `SPW_OFF_DIV)
      div_q <= pwdata & 32'hFFFF_FFFE;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------
  // Serial clock
  // ----------------------------------------
  // Half period of 2*(divisor+1) pclk cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hcnt_q <= '0;
      sclk_q <= 1'b0;
    end
    else if (!en_any || !internal_clock_select)
    begin
      hcnt_q <= {cdiv, 1'b1};
      sclk_q <= 1'b0;
    end
    else if (hcnt_q == 16'h0)
    begin
      hcnt_q <= {cdiv, 1'b1};
      sclk_q <= !sclk_q;
    end
    else
      hcnt_q <= hcnt_q - 16'h1;
  end

  // Pins cross into pclk through two flops before any use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      fs_s1 <= 1'b0;
      fs_s2 <= 1'b0;
      din_s1 <= 2'h0;
      din_s2 <= 2'h0;
      sclk_oe_q <= 1'b0;
    end
    else
    begin
      ck_s1 <= sclk_in;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      fs_s1 <= fs_in;
      fs_s2 <= fs_s1;
      din_s1 <= dat_in;
      din_s2 <= din_s1;
      sclk_oe_q <= en_any && internal_clock_select;
    end
  end

  // One tick pair times both data lines
  assign rise_tick = en_any && (internal_clock_select ? (hcnt_q == 16'h0 && !sclk_q) : (ck_s2 && !ck_s3));
  assign fall_tick = en_any && (internal_clock_select ? (hcnt_q == 16'h0 && sclk_q) : (!ck_s2 && ck_s3));

  assign sclk_out = sclk_q;
  assign sclk_oe = sclk_oe_q;

  // ----------------------------------------
  // Frame sync
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fcnt_q <= '0;
      fs_q <= 1'b0;
      fs_oe_q <= 1'b0;
    end
    else
    begin
      fs_oe_q <= en_any && ifs;
      if (!en_any || !ifs)
      begin
        fcnt_q <= fper;
        fs_q <= 1'b0;
      end
      else if (rise_tick)
      begin
        if (fcnt_q == 16'h0)
        begin
          fcnt_q <= fper;
          fs_q <= 1'b1;
        end
        else
        begin
          fcnt_q <= fcnt_q - 16'h1;
          fs_q <= 1'b0;
        end
      end
    end
  end

  assign fs_out = fs_q;
  assign fs_oe = fs_oe_q;
  assign fs_seen = ifs ? fs_q : fs_s2;

  // ----------------------------------------
  // Bit sequencer
  // ----------------------------------------
  // Frame sync starts a word in whichever direction is set
  assign last = st_q == SPW_SHIFT && bcnt_q == wlen;
  assign start = rise_tick && fs_seen && (st_q == SPW_IDLE || last);
  assign idx = low_bit_first_select ? bcnt_q : wlen - bcnt_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= SPW_IDLE;
      bcnt_q <= '0;
    end
    else if (!en_any)
      st_q <= SPW_IDLE;
    else if (rise_tick)
    begin
      unique case (st_q)
        SPW_IDLE:
        begin
          if (start)
          begin
            st_q <= SPW_SHIFT;
            bcnt_q <= '0;
          end
        end
        SPW_SHIFT:
        begin
          if (start)
            bcnt_q <= '0;
          else if (last)
            st_q <= SPW_IDLE;
          else
            bcnt_q <= bcnt_q + 5'h1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Companding
  // ----------------------------------------
  // Disabled port means the expander serves buffer writes in place
  assign dec_in = en_any ? rx_low_a : pwdata[7:0];

  spw_compand u_cmp (
    .law_a(fmt[0]),
    .lin_in(pwdata),
    .code_out(enc_code),
    .code_in(dec_in),
    .lin_out(dec_lin)
  );

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    localparam logic [7:0] TX_OFF = (ch == 0) ? `SPW_OFF_TXA : `SPW_OFF_TXB;
    localparam logic [7:0] RX_OFF = (ch == 0) ? `SPW_OFF_RXA : `SPW_OFF_RXB;
    localparam logic A_CH = ch == 0;
    logic en_ch, sx, tx_go;
    spw_word_t tbuf_q, txw_q, rbuf_q, rsh_q, rnow, fv, cur;
    logic [15:0] racc_q;
    logic tfull_q, rfull_q, thalf_q, rhalf_q, dout_q, doe_q, tevt_q, revt_q;

    assign en_ch = A_CH ? en_a : en_b;
    assign tx_go = start && xmit && en_ch && !(merge && thalf_q);
    assign rnow = put_bit(rsh_q, idx, din_s2[ch]);
    assign sx = (!A_CH && mc) ? mcfmt[0] : (!fmt[1] && fmt[0]);
    assign fv = (A_CH && !CAN_COMP && fmt[1]) ? dec_lin : extend(rnow, wlen, sx);
    // Second half of a merged word comes from the upper bits
    assign cur = !merge ? txw_q : {16'h0, thalf_q ? txw_q[15:0] : txw_q[31:16]};

    if (A_CH)
    begin : g_a
      assign rx_low_a = rnow[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        tbuf_q <= '0;
        tfull_q <= 1'b0;
      end
      else if (wr_go && paddr == TX_OFF)
      begin
        tbuf_q <= (A_CH && CAN_COMP && fmt[1]) ? {24'h0, enc_code} : pwdata;
        tfull_q <= 1'b1;
      end
      else if (tx_go)
        tfull_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        txw_q <= '0;
        thalf_q <= 1'b0;
        tevt_q <= 1'b0;
      end
      else
      begin
        tevt_q <= tx_go && tfull_q;
        if (!en_ch)
          thalf_q <= 1'b0;
        else if (start && xmit)
        begin
          if (merge && thalf_q)
            thalf_q <= 1'b0;
          else
          begin
            // Empty buffer sends zeros rather than stale data
            txw_q <= tfull_q ? tbuf_q : '0;
            thalf_q <= merge;
          end
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        dout_q <= 1'b0;
        doe_q <= 1'b0;
      end
      else
      begin
        doe_q <= en_ch && xmit;
        if (fall_tick && st_q == SPW_SHIFT)
          dout_q <= cur[idx];
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        rsh_q <= '0;
        racc_q <= '0;
        rbuf_q <= '0;
        rfull_q <= 1'b0;
        rhalf_q <= 1'b0;
        revt_q <= 1'b0;
      end
      else
      begin
        revt_q <= 1'b0;
        if (rd_go && paddr == RX_OFF)
          rfull_q <= 1'b0;
        if (!en_ch)
          rhalf_q <= 1'b0;
        if (wr_go && paddr == RX_OFF && !en_any)
          rbuf_q <= (A_CH && !CAN_COMP && fmt[1]) ? dec_lin : pwdata;
        if (rise_tick && st_q == SPW_SHIFT && en_ch && !xmit)
        begin
          rsh_q <= rnow;
          if (last && merge && !rhalf_q)
          begin
            racc_q <= fv[15:0];
            rhalf_q <= 1'b1;
          end
          else if (last)
          begin
            rbuf_q <= merge ? {fv[15:0], racc_q} : fv;
            rfull_q <= 1'b1;
            rhalf_q <= 1'b0;
            revt_q <= 1'b1;
          end
        end
      end
    end

    assign dat_out[ch] = dout_q;
    assign dat_oe[ch] = doe_q;
    assign tx_evt[ch] = tevt_q;
    assign rx_evt[ch] = revt_q;
    assign tbuf_w[ch] = tbuf_q;
    assign rbuf_w[ch] = rbuf_q;
    assign tfull_w[ch] = tfull_q;
    assign rfull_w[ch] = rfull_q;

    if (A_CH)
    begin : g_ast_a
      AST_TX_COMP: assert property (@(posedge pclk) disable iff (!presetn)
        wr_go && paddr == TX_OFF && CAN_COMP && fmt[1]
        |=> tbuf_q[31:8] == 24'h0 && tbuf_q[7:0] == $past(enc_code))
        else $error("compressed write not reduced to a zero-filled code");
      AST_LSB_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        fall_tick && st_q == SPW_SHIFT && low_bit_first_select |=> dout_q == $past(cur[bcnt_q]))
        else $error("low-bit-first order not followed");
      AST_MERGE_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
        rise_tick && last && merge && !rhalf_q && en_ch && !xmit |=> !revt_q && rhalf_q)
        else $error("event raised for first half of merged word");
      AST_TX_SPLIT: assert property (@(posedge pclk) disable iff (!presetn)
        tx_go && merge |=> thalf_q && tevt_q == $past(tfull_q))
        else $error("merged transmit word not split in two");
    end
    else
    begin : g_ast_b
      AST_RXB_FILL: assert property (@(posedge pclk) disable iff (!presetn)
        revt_q && !mc && fmt[1] && !merge |-> (rbuf_q & ~mask_w) == 32'h0)
        else $error("channel B did not zero-fill during companding");
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_DIV_HALF: assert property (@(posedge pclk) disable iff (!presetn)
    en_any && internal_clock_select && hcnt_q == 16'h0 ##1 en_any && internal_clock_select
    |-> sclk_q != $past(sclk_q) && hcnt_q == {$past(cdiv), 1'b1})
    else $error("serial clock half period wrong");
  AST_EXT_CLK: assert property (@(posedge pclk) disable iff (!presetn)
    !internal_clock_select ##1 !internal_clock_select |-> !sclk_oe_q && !sclk_q)
    else $error("clock pin driven while external clock selected");
  AST_FS_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
    en_any && ifs && rise_tick && fcnt_q == 16'h0 |=> fs_q && fcnt_q == $past(fper))
    else $error("frame sync not issued at period end");
  AST_FS_CONT: assert property (@(posedge pclk) disable iff (!presetn)
    en_any && ifs && fper == 16'h0 && rise_tick ##1 en_any && ifs |-> fs_q)
    else $error("frame sync dropped with zero period");
  AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    !en_any ##1 !en_any |-> hcnt_q == {$past(cdiv), 1'b1} && fcnt_q == $past(fper) && !fs_q)
    else $error("counters not reloaded while disabled");

endmodule // spw_port

// ### dv/spw_codec_model.sv
// Purpose: far-side serial codec for one port, data lines A and B
// Assumes: early frame sync, active high, seen on serial rising edge
// Notes: sends word_tx MSB first on both lines and captures line A
`timescale 1ns/10ps

module spw_codec_model (
  input wire logic sclk, // Serial clock from the port
  input wire logic fs, // Frame sync from the port
  input wire logic dout, // Data line A from the port
  input wire logic [4:0] wlen, // Word length minus one
  input wire logic [31:0] word_tx, // Word to send
  output logic [1:0] din, // Data to the port, both lines
  output logic [31:0] cap, // Last word captured
  output int nfr // Words captured so far
);
  logic [5:0] cnt;
  logic [31:0] sh;
  logic fs_l;

  initial
  begin
    cnt = 6'h00;
    din = 2'h0;
    cap = 32'h0;
    sh = 32'h0;
    fs_l = 1'b0;
    nfr = 0;
  end

  always @(posedge sclk)
  begin
    if (cnt == 6'h00)
    begin
      sh <= 32'h0;
      if (fs_l)
        cnt <= {1'b0, wlen} + 6'h01;
    end
    else
    begin
      sh <= {sh[30:0], dout};
      cnt <= cnt - 6'h01;
      if (cnt == 6'h01)
      begin
        cap <= {sh[30:0], dout};
        nfr <= nfr + 1;
      end
    end
  end

  // Outside a word the line toggles, so a port that samples late sees garbage
  // Frame sync moves with the rising edge, so it is taken mid-period
  always @(negedge sclk)
  begin
    fs_l <= fs;
    if (cnt != 6'h00)
      din <= {2{word_tx[cnt - 6'h01]}};
    else
      din <= ~din;
  end
endmodule // spw_codec_model

// ### dv/tb_top.sv
// Purpose: self-checking bench for spw_port with a codec on the far side
// Assumes: port index 0, internal frame sync, internal clock except the one external-clock case, 10 MHz pclk
// Notes: word rows first, then in-place, framing, divider and reset cases
`timescale 1ns/10ps
`include "spw_defs.svh"

module tb_top;
  import spw_pkg::*;
  typedef struct packed {logic [31:0] ctrl; logic [7:0] bufa; spw_word_t dat; spw_word_t exp;} spw_row_s;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [7:0] paddr;
  spw_word_t pwdata, prdata, cap, word_tx, rd;
  logic pready, pslverr, sclk_out, sclk_oe, fs_out, fs_oe;
  logic [1:0] dat_in, dat_out, dat_oe, din, tx_evt, rx_evt;
  logic [4:0] wlen;
  int nfr, failures, n_checks, n0, k, cyc, n, ntx;
  spw_row_s rows [12];

  assign dat_in = (dat_oe & dat_out) | (~dat_oe & din);

  spw_port #(.PORT_INDEX(0)) i_spw_port (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclk_in(cyc[3]), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .fs_in(1'b0), .fs_out(fs_out), .fs_oe(fs_oe), .dat_in(dat_in),
    .dat_out(dat_out), .dat_oe(dat_oe), .tx_evt(tx_evt), .rx_evt(rx_evt));
  spw_codec_model i_spw_codec_model (.sclk(sclk_out), .fs(fs_out), .dout(dat_out[0]),
    .wlen(wlen), .word_tx(word_tx), .din(din), .cap(cap), .nfr(nfr));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic timeout;
    failures++;
    $display("wait limit ran out");
    report_and_stop;
  endtask
  task automatic chk(input string what, input spw_word_t exp, input spw_word_t got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input spw_word_t d, output spw_word_t r);
    int i;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 50)
      timeout;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_lvl(input logic fsel, input logic lvl);
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge pclk);
      if ((fsel ? fs_out : sclk_out) === lvl)
        return;
    end
    timeout;
  endtask
  // Rising edge to rising edge, in pclk cycles
  task automatic meas(input logic fsel, output int p);
    int t0;
    wait_lvl(fsel, 1'b0);
    wait_lvl(fsel, 1'b1);
    t0 = cyc;
    wait_lvl(fsel, 1'b0);
    wait_lvl(fsel, 1'b1);
    p = cyc - t0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, err, cyc} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    word_tx = 32'h0;
    wlen = 5'h07;
    failures = 0;
    n_checks = 0;
    rows = '{'{32'h701D, `SPW_OFF_TXA, 32'hA5, 32'hA5},
      '{32'h703D, `SPW_OFF_TXA, 32'h01, 32'h80},
      '{32'h301D, `SPW_OFF_TXA, 32'hFFFFFFF9, 32'h9},
      '{32'h731D, `SPW_OFF_TXA, 32'h7FFFFFFF, 32'hAA},
      '{32'h721D, `SPW_OFF_TXA, 32'h7FFFFFFF, 32'h80},
      '{32'hF05D, `SPW_OFF_TXA, 32'h22221111, 32'h2222},
      '{32'h7119, `SPW_OFF_RXA, 32'h85, 32'hFFFFFF85},
      '{32'h7019, `SPW_OFF_RXA, 32'h85, 32'h85},
      '{32'h7039, `SPW_OFF_RXA, 32'h01, 32'h80},
      '{32'hF059, `SPW_OFF_RXA, 32'h1234, 32'h12341234},
      '{32'h731A, `SPW_OFF_RXB, 32'h85, 32'h85},
      '{32'h749A, `SPW_OFF_RXB, 32'h85, 32'hFFFFFF85}};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      wlen <= rows[i].ctrl[16:12];
      word_tx <= rows[i].dat;
      apb(`SPW_OFF_DIV, 1'b1, 32'h0021_0002, rd);
      apb(`SPW_OFF_CTRL, 1'b1, rows[i].ctrl & ~32'h3, rd);
      if (rows[i].ctrl[2])
        apb(`SPW_OFF_TXA, 1'b1, rows[i].dat, rd);
      n0 = nfr;
      ntx = 0;
      apb(`SPW_OFF_CTRL, 1'b1, rows[i].ctrl, rd);
      for (k = 0; k < 3000; k++)
      begin
        @(posedge pclk);
        ntx += int'(tx_evt[0]) + int'(tx_evt[1]);
        if (rows[i].ctrl[2] ? (nfr >= n0 + 1 + rows[i].ctrl[6]) : (rx_evt != 2'b00))
          break;
      end
      if (k == 3000)
        timeout;
      if (rows[i].ctrl[2])
        rd = cap;
      else
        apb(rows[i].bufa, 1'b0, 32'h0, rd);
      chk("row word", rows[i].exp, rd);
      chk("transmit events", {31'h0, rows[i].ctrl[2]}, 32'(ntx));
    end
    $display("word rows done");
    for (int j = 0; j < 2; j++)
    begin
      apb(`SPW_OFF_CTRL, 1'b1, j ? 32'h7304 : 32'h7204, rd);
      apb(`SPW_OFF_TXA, 1'b1, 32'h7FFFFFFF, rd);
      repeat (2) @(posedge pclk);
      apb(`SPW_OFF_TXA, 1'b0, 32'h0, rd);
      chk("in-place code", j ? 32'hAA : 32'h80, rd);
    end
    apb(`SPW_OFF_RXA, 1'b1, 32'h0000_00AA, rd);
    repeat (2) @(posedge pclk);
    apb(`SPW_OFF_RXA, 1'b0, 32'h0, rd);
    chk("in-place receive", 32'hAA, rd);
    apb(8'h1C, 1'b0, 32'h0, rd);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("in-place and unmapped done");
    apb(`SPW_OFF_DIV, 1'b1, 32'h0005_0004, rd);
    apb(`SPW_OFF_CTRL, 1'b1, 32'h7019, rd);
    meas(1'b0, n);
    chk("serial period", 32'd12, 32'(n));
    chk("clock drive", 32'h1, {31'h0, sclk_oe});
    meas(1'b1, n);
    chk("frame period", 32'd72, 32'(n));
    chk("frame drive", 32'h1, {31'h0, fs_oe});
    apb(`SPW_OFF_CTRL, 1'b1, 32'h7018, rd);
    apb(`SPW_OFF_DIV, 1'b1, 32'h0000_0004, rd);
    apb(`SPW_OFF_CTRL, 1'b1, 32'h7019, rd);
    wait_lvl(1'b1, 1'b1);
    n = 0;
    repeat (40)
    begin
      @(posedge pclk);
      n += int'(fs_out === 1'b1);
    end
    chk("steady frame sync", 32'd40, 32'(n));
    apb(`SPW_OFF_CTRL, 1'b1, 32'h7011, rd);
    repeat (3) @(posedge pclk);
    chk("clock input", 32'h0, {31'h0, sclk_oe});
    apb(`SPW_OFF_DIV, 1'b1, 32'h0005_0000, rd);
    meas(1'b1, n);
    chk("external frame period", 32'd96, 32'(n));
    $display("divider and framing done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("enables in reset", 32'h0, {27'h0, sclk_oe, fs_oe, dat_oe, pready});
    presetn <= 1'b1;
    apb(`SPW_OFF_CTRL, 1'b0, 32'h0, rd);
    chk("control reset", `SPW_CTRL_RST, rd);
    apb(`SPW_OFF_DIV, 1'b0, 32'h0, rd);
    chk("divisor reset", `SPW_DIV_RST, rd);
    $display("reset done");
    report_and_stop;
  end
endmodule // tb_top
